/* File: logic/lss_cfg.svh */
// register offsets, reset values and timing counts of the line supply supervisor
`ifndef LSS_CFG_SVH
`define LSS_CFG_SVH
`define LSS_CLK_HZ 50000000
`define LSS_OFF_STATUS 8'h00
`define LSS_OFF_SUPPLY 8'h04
`define LSS_OFF_DCCFG 8'h08
`define LSS_OFF_LVLPCT 8'h0C
`define LSS_OFF_LVLV 8'h10
`define LSS_OFF_DYN 8'h14
`define LSS_OFF_TLIM 8'h18
`define LSS_OFF_SFLOOR 8'h1C
`define LSS_OFF_CONTACT 8'h20
`define LSS_OFF_WATCH 8'h24
`define LSS_OFF_HOLD 8'h28
`define LSS_OFF_IRQST 8'h2C
`define LSS_OFF_IRQMASK 8'h30
`define LSS_OFF_FAULT 8'h34
`define LSS_RST_SUPPLY 16'h0190
`define LSS_RST_DCCFG 2'h1
`define LSS_RST_LVLPCT 16'h004C
`define LSS_RST_DYN 16'h012C
`define LSS_RST_TLIM 16'h0000
`define LSS_RST_SFLOOR 16'h0032
`define LSS_RST_WATCH 16'h0064
`define LSS_RST_HOLD 16'h0032
`define LSS_BIT_BUF_ACTIVE 15
`define LSS_CYC_PER_MS (`LSS_CLK_HZ / 1000)
`endif

/* File: logic/lss_pkg.sv */
// types of the line supply supervisor
package lss_pkg;
	typedef enum logic [3:0] {
		LSS_OPEN = 4'b0001,
		LSS_CLOSED = 4'b0010,
		LSS_HOLD = 4'b0100,
		LSS_OPENING = 4'b1000
	} lss_contact_e;
endpackage : lss_pkg

/* File: logic/lss_supervisor.sv */
// line supply supervisor: undervoltage buffering and contactor sequencing
//
// The address map and register access over AHB-Lite were chosen for this implementation.
`include "lss_cfg.svh"
module lss_supervisor
	import lss_pkg::*;
#(
	parameter int MS_CYCLES = `LSS_CYC_PER_MS
) (
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire logic [15:0] DC_LINK_VOLTS,
	input wire logic [15:0] MOTOR_SPEED_RPM,
	input wire logic MOTOR_ON_REQUEST,
	input wire logic RAMP_STOP_COMMAND,
	input wire logic SAFE_TORQUE_OFF,
	input wire logic CONTACT_AUX_IN,
	output logic CONTACTOR_OUT,
	output logic BUFFERING_ACTIVE,
	output logic MOTOR_ENABLE,
	output logic OVERVOLT_CTRL_EN,
	output logic [15:0] DYN_FACTOR,
	output logic IRQ
);
	// pin synchronisers
	logic [15:0] dc_s1, dc_s2, spd_s1, spd_s2;
	logic [3:0] pin_s1, pin_s2;
	always_ff @(posedge CLOCK) begin
		dc_s1 <= DC_LINK_VOLTS;
		dc_s2 <= dc_s1;
		spd_s1 <= MOTOR_SPEED_RPM;
		spd_s2 <= spd_s1;
		pin_s1 <= {MOTOR_ON_REQUEST, RAMP_STOP_COMMAND, SAFE_TORQUE_OFF,
			CONTACT_AUX_IN};
		pin_s2 <= pin_s1;
	end
	wire on_req = pin_s2[3];
	wire ramp_stop = pin_s2[2];
	wire safe_torque_off = pin_s2[1];
	wire aux_in = pin_s2[0];

	// registers
	logic [15:0] supply_voltage_setting, buffering_level_percent;
	logic [15:0] buffering_dynamic_factor, buffering_time_limit;
	logic [15:0] buffering_speed_floor, contactor_watch_time;
	logic [15:0] contactor_hold_delay;
	logic [1:0] dc_link_controller_config;
	logic route_en, fb_sel, sequence_config;
	logic [2:0] irq_status, irq_mask, fault;

	// AHB-Lite slave, zero wait states
	logic wr_pend, rd_pend;
	logic [7:0] a_q;
	wire take = HSEL && HREADY && HTRANS[1];
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			wr_pend <= 1'b0;
			a_q <= 8'h00;
		end else begin
			wr_pend <= take && HWRITE;
			if (take)
				a_q <= HADDR[7:0];
		end
	end
	wire [7:0] ra = HADDR[7:0];

	// threshold: pct * 1.41421 * supply / 100, 1.41421 as 46341/32768
	function automatic logic [15:0] lss_level(input logic [15:0] pct,
		input logic [15:0] sup);
		logic [47:0] p;
		p = 48'(pct) * 48'(sup) * 48'd46341;
		return 16'(p / 48'd3276800);
	endfunction : lss_level
	wire [15:0] buffering_level_volts = lss_level(buffering_level_percent,
		supply_voltage_setting);

	// undervoltage buffering
	wire buf_en = dc_link_controller_config[1];
	logic buf_act;
	wire [15:0] status_word = {buf_act, 15'h0000};
	wire next_buf = buf_en && (dc_s2 <= buffering_level_volts);

	// millisecond tick
	logic [31:0] ms_div;
	wire ms_tick = (ms_div == 32'(MS_CYCLES - 1));
	always_ff @(posedge CLOCK) begin
		if (RST || ms_tick)
			ms_div <= 32'h0000_0000;
		else
			ms_div <= ms_div + 32'h0000_0001;
	end

	// buffering duration in ms, time limit held in ms
	logic [15:0] buf_ms;
	wire tlim_hit = (buffering_time_limit != 16'h0000) && buf_act &&
		(buf_ms >= buffering_time_limit);
	wire speed_low = buf_act && (spd_s2 < buffering_speed_floor);

	// contactor sequencing
	lss_contact_e st;
	logic [15:0] seq_ms;
	wire fb = fb_sel ? ~aux_in : CONTACTOR_OUT;
	wire hold_done = (seq_ms >= contactor_hold_delay);
	wire fb_late = fb_sel && (seq_ms >= contactor_watch_time);
	wire cmd_close = (st == LSS_CLOSED) || (st == LSS_HOLD);
	logic watch_pend;
	wire fb_fault = watch_pend && fb_late && (fb != cmd_close);
	lss_contact_e next_st;
	always_comb begin
		next_st = st;
		unique case (st)
			LSS_OPEN:
				if (route_en && on_req && !safe_torque_off && !ramp_stop)
					next_st = LSS_CLOSED;
			LSS_CLOSED:
				if (!route_en || (safe_torque_off && !sequence_config))
					next_st = LSS_OPENING;
				else if (ramp_stop || safe_torque_off || !on_req)
					next_st = LSS_HOLD;
			LSS_HOLD:
				if (safe_torque_off && !sequence_config)
					next_st = LSS_OPENING;
				else if (on_req && !ramp_stop && !safe_torque_off)
					next_st = LSS_CLOSED;
				else if (hold_done)
					next_st = LSS_OPENING;
			LSS_OPENING:
				next_st = LSS_OPEN;
		endcase
	end
	wire st_change = (next_st != st);

	wire [2:0] events = {fb_fault, tlim_hit, speed_low};
	wire rd_status = take && !HWRITE && (ra == `LSS_OFF_IRQST);

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			buf_act <= 1'b0;
			buf_ms <= 16'h0000;
			st <= LSS_OPEN;
			seq_ms <= 16'h0000;
			watch_pend <= 1'b0;
		end else begin
			buf_act <= next_buf;
			if (!buf_act)
				buf_ms <= 16'h0000;
			else if (ms_tick && buf_ms != 16'hFFFF)
				buf_ms <= buf_ms + 16'h0001;
			st <= next_st;
			if (st_change)
				seq_ms <= 16'h0000;
			else if (ms_tick && seq_ms != 16'hFFFF)
				seq_ms <= seq_ms + 16'h0001;
			// each close or open command rearms the watch
			if (st_change && (next_st == LSS_CLOSED || next_st == LSS_OPENING))
				watch_pend <= 1'b1;
			else if (fb == cmd_close || fb_fault)
				watch_pend <= 1'b0;
		end
	end

	// register writes, one short process per register
	wire wr = wr_pend;
	wire wr_supply = wr && (a_q == `LSS_OFF_SUPPLY);
	wire wr_dccfg = wr && (a_q == `LSS_OFF_DCCFG);
	wire wr_lvlpct = wr && (a_q == `LSS_OFF_LVLPCT);
	wire wr_dyn = wr && (a_q == `LSS_OFF_DYN);
	wire wr_tlim = wr && (a_q == `LSS_OFF_TLIM);
	wire wr_sfloor = wr && (a_q == `LSS_OFF_SFLOOR);
	wire wr_watch = wr && (a_q == `LSS_OFF_WATCH);
	wire wr_hold = wr && (a_q == `LSS_OFF_HOLD);
	wire wr_contact = wr && (a_q == `LSS_OFF_CONTACT);
	wire wr_mask = wr && (a_q == `LSS_OFF_IRQMASK);
	wire wr_fault = wr && (a_q == `LSS_OFF_FAULT);

	always_ff @(posedge CLOCK) begin
		if (RST)
			supply_voltage_setting <= `LSS_RST_SUPPLY;
		else if (wr_supply)
			supply_voltage_setting <= HWDATA[15:0];
	end

	always_ff @(posedge CLOCK) begin
		if (RST)
			dc_link_controller_config <= `LSS_RST_DCCFG;
		else if (wr_dccfg)
			dc_link_controller_config <= HWDATA[1:0];
	end

	always_ff @(posedge CLOCK) begin
		if (RST)
			buffering_level_percent <= `LSS_RST_LVLPCT;
		else if (wr_lvlpct)
			buffering_level_percent <= HWDATA[15:0];
	end

	always_ff @(posedge CLOCK) begin
		if (RST)
			buffering_dynamic_factor <= `LSS_RST_DYN;
		else if (wr_dyn)
			buffering_dynamic_factor <= HWDATA[15:0];
	end

	always_ff @(posedge CLOCK) begin
		if (RST)
			buffering_time_limit <= `LSS_RST_TLIM;
		else if (wr_tlim)
			buffering_time_limit <= HWDATA[15:0];
	end

	always_ff @(posedge CLOCK) begin
		if (RST)
			buffering_speed_floor <= `LSS_RST_SFLOOR;
		else if (wr_sfloor)
			buffering_speed_floor <= HWDATA[15:0];
	end

	always_ff @(posedge CLOCK) begin
		if (RST)
			contactor_watch_time <= `LSS_RST_WATCH;
		else if (wr_watch)
			contactor_watch_time <= HWDATA[15:0];
	end

	always_ff @(posedge CLOCK) begin
		if (RST)
			contactor_hold_delay <= `LSS_RST_HOLD;
		else if (wr_hold)
			contactor_hold_delay <= HWDATA[15:0];
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			route_en <= 1'b0;
			fb_sel <= 1'b0;
			sequence_config <= 1'b0;
		end else if (wr_contact) begin
			route_en <= HWDATA[0];
			fb_sel <= HWDATA[1];
			sequence_config <= HWDATA[2];
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RST)
			irq_mask <= 3'h0;
		else if (wr_mask)
			irq_mask <= HWDATA[2:0];
	end

	// fault: write one to acknowledge, irq status: cleared by its read; a new event wins over either clear
	wire [2:0] fault_kept = wr_fault ? (fault & ~HWDATA[2:0]) : fault;
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			fault <= 3'h0;
			irq_status <= 3'h0;
		end else begin
			fault <= fault_kept | events;
			irq_status <= (rd_status ? 3'h0 : irq_status) | events;
		end
	end

	// read mux, data presented in the data phase
	logic [31:0] rdata;
	always_comb begin
		unique case (ra)
			`LSS_OFF_STATUS: rdata = {16'h0000, status_word};
			`LSS_OFF_SUPPLY: rdata = {16'h0000, supply_voltage_setting};
			`LSS_OFF_DCCFG: rdata = {30'h0, dc_link_controller_config};
			`LSS_OFF_LVLPCT: rdata = {16'h0000, buffering_level_percent};
			`LSS_OFF_LVLV: rdata = {16'h0000, buffering_level_volts};
			`LSS_OFF_DYN: rdata = {16'h0000, buffering_dynamic_factor};
			`LSS_OFF_TLIM: rdata = {16'h0000, buffering_time_limit};
			`LSS_OFF_SFLOOR: rdata = {16'h0000, buffering_speed_floor};
			`LSS_OFF_CONTACT: rdata = {25'h0, st, sequence_config, fb_sel,
				route_en};
			`LSS_OFF_WATCH: rdata = {16'h0000, contactor_watch_time};
			`LSS_OFF_HOLD: rdata = {16'h0000, contactor_hold_delay};
			`LSS_OFF_IRQST: rdata = {29'h0, irq_status};
			`LSS_OFF_IRQMASK: rdata = {29'h0, irq_mask};
			`LSS_OFF_FAULT: rdata = {29'h0, fault};
			default: rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			HRDATA <= 32'h0000_0000;
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
			CONTACTOR_OUT <= 1'b0;
			BUFFERING_ACTIVE <= 1'b0;
			MOTOR_ENABLE <= 1'b0;
			OVERVOLT_CTRL_EN <= 1'b1;
			DYN_FACTOR <= `LSS_RST_DYN;
			IRQ <= 1'b0;
		end else begin
			HRDATA <= (take && !HWRITE) ? rdata : 32'h0000_0000;
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
			// drive only when routed to the output
			CONTACTOR_OUT <= route_en && (next_st == LSS_CLOSED ||
				next_st == LSS_HOLD);
			BUFFERING_ACTIVE <= next_buf;
			// motor waits one cycle after the contactor closes
			// never enabled in a cycle in which the contactor is let go
			MOTOR_ENABLE <= (st == LSS_CLOSED) && (next_st == LSS_CLOSED) &&
				!safe_torque_off;
			OVERVOLT_CTRL_EN <= dc_link_controller_config[0];
			DYN_FACTOR <= buffering_dynamic_factor;
			IRQ <= |(((rd_status ? 3'h0 : irq_status) | events) & irq_mask);
		end
	end
endmodule : lss_supervisor

/* File: verification/lss_contact_model.sv */
// line contactor with an auxiliary contact that follows the coil late
module lss_contact_model #(
	parameter int DLY = 5
) (
	input wire logic clock,
	input wire logic coil,
	input wire logic stuck,
	output logic aux
);
	timeunit 1ns;
	timeprecision 1ns;
	logic closed = 1'b0;
	int t = 0;
	// a welded contact never moves, so feedback stays behind the command
	always @(posedge clock) begin
		t <= (coil == closed || stuck) ? 0 : t + 1;
		if (t == DLY) closed <= coil;
	end
	assign aux = !closed;
endmodule : lss_contact_model

/* File: verification/lss_supervisor_sva.sv */
// port assertions of the line supply supervisor
module lss_supervisor_sva (
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic HREADY,
	input wire logic [31:0] HRDATA,
	input wire logic HREADYOUT,
	input wire logic HRESP,
	input wire logic MOTOR_ON_REQUEST,
	input wire logic RAMP_STOP_COMMAND,
	input wire logic SAFE_TORQUE_OFF,
	input wire logic CONTACTOR_OUT,
	input wire logic BUFFERING_ACTIVE,
	input wire logic MOTOR_ENABLE,
	input wire logic [15:0] DYN_FACTOR,
	input wire logic IRQ
);
	wire rd = HSEL && HREADY && HTRANS[1] && !HWRITE;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RST);
	reset_clear_a: assert property (disable iff (1'b0)
		RST |=> !CONTACTOR_OUT && !BUFFERING_ACTIVE && !IRQ) else $error("reset");
	bus_okay_a: assert property (HREADYOUT && !HRESP) else $error("bus resp");
	status_bit_a: assert property (rd && HADDR == 32'h0 &&
		$stable(BUFFERING_ACTIVE) |=> HRDATA[15] == $past(BUFFERING_ACTIVE))
		else $error("status bit");
	unmapped_zero_a: assert property (rd && HADDR == 32'h3C |=> HRDATA == 32'h0)
		else $error("unmapped read");
	dyn_reset_a: assert property ($fell(RST) |-> DYN_FACTOR == 16'h012C)
		else $error("dyn factor");
	close_cause_a: assert property ($rose(CONTACTOR_OUT) |->
		MOTOR_ON_REQUEST && $past(MOTOR_ON_REQUEST, 2) && !SAFE_TORQUE_OFF)
		else $error("close cause");
	motor_closed_a: assert property (MOTOR_ENABLE |-> CONTACTOR_OUT)
		else $error("motor without line");
	hold_stop_a: assert property (
		$rose(RAMP_STOP_COMMAND) && CONTACTOR_OUT && !SAFE_TORQUE_OFF
		|=> CONTACTOR_OUT [*8]) else $error("hold");
	cover property (BUFFERING_ACTIVE);
	cover property ($fell(CONTACTOR_OUT));
	cover property ($rose(IRQ));
endmodule : lss_supervisor_sva
bind lss_supervisor lss_supervisor_sva sva (.CLOCK, .RST, .HSEL, .HADDR,
	.HTRANS, .HWRITE, .HREADY, .HRDATA, .HREADYOUT, .HRESP, .MOTOR_ON_REQUEST,
	.RAMP_STOP_COMMAND, .SAFE_TORQUE_OFF, .CONTACTOR_OUT, .BUFFERING_ACTIVE,
	.MOTOR_ENABLE, .DYN_FACTOR, .IRQ);

/* File: verification/lss_supervisor_bench.sv */
// bench of the line supply supervisor
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fails++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module lss_supervisor_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int LV = 76 * 400 * 46341 / 3276800;
	logic clock = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, on = 1'b0;
	logic rs = 1'b0, safe_torque_off = 1'b0, stuck = 1'b0, aux, co, ba, ov, irq, rdy, i0;
	logic me;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
	logic [15:0] dc = 16'h0230, spd = 16'h03E8, dyn;
	logic [7:0] ra [10] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C,
		8'h24, 8'h28, 8'h3C};
	logic [15:0] rv [10] = '{16'h0190, 16'h0001, 16'h004C, 16'(LV), 16'h012C,
		16'h0000, 16'h0032, 16'h0064, 16'h0032, 16'h0000};
	int fails = 0, total_checks = 0, n;
	lss_supervisor #(.MS_CYCLES(10)) dut (.CLOCK(clock), .RST(rst),
		.HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
		.HSIZE(3'h2), .HWDATA(hwdata), .HREADY(rdy), .HRDATA(hrdata),
		.HREADYOUT(rdy), .HRESP(), .DC_LINK_VOLTS(dc), .MOTOR_SPEED_RPM(spd),
		.MOTOR_ON_REQUEST(on), .RAMP_STOP_COMMAND(rs), .SAFE_TORQUE_OFF(safe_torque_off),
		.CONTACT_AUX_IN(aux), .CONTACTOR_OUT(co), .BUFFERING_ACTIVE(ba),
		.MOTOR_ENABLE(me), .OVERVOLT_CTRL_EN(ov), .DYN_FACTOR(dyn), .IRQ(irq));
	lss_contact_model cm (.clock(clock), .coil(co), .stuck(stuck), .aux(aux));
	initial forever #10 clock = ~clock;
	task cyc(input int k);
		repeat (k) @(posedge clock);
	endtask : cyc
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge clock); while (rdy !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clock); while (rdy !== 1'b1);
		r = hrdata;
	endtask : bus
	task t_regs;
		for (int i = 0; i < 10; i++) begin
			bus(1'b0, ra[i], 32'h0);
			`CHK(r, {16'h0, rv[i]})
		end
		`CHK(dyn, 16'h012C)
		`CHK(ov, 1'b1)
		$display("reset values end");
	endtask : t_regs
	task t_buf;
		for (int c = 0; c < 4; c++) begin
			bus(1'b1, 8'h08, c);
			dc <= 16'h0190;
			cyc(6);
			bus(1'b0, 8'h00, 32'h0);
			`CHK(ba, c[1])
			`CHK(r[15], c[1])
			`CHK(ov, c[0])
			dc <= 16'h0230;
			cyc(4);
			`CHK(ba, 1'b0)
		end
		$display("buffering end");
	endtask : t_buf
	task t_fault;
		dc <= 16'h0190;
		cyc(40);
		bus(1'b0, 8'h34, 32'h0);
		`CHK(r[2:0], 3'h0)
		bus(1'b1, 8'h18, 32'h2);
		cyc(40);
		spd <= 16'h0028;
		cyc(6);
		i0 = irq;
		bus(1'b1, 8'h30, 32'h7);
		cyc(2);
		`CHK(irq ^ i0, 1'b1)
		dc <= 16'h0230;
		spd <= 16'h03E8;
		cyc(4);
		bus(1'b0, 8'h34, 32'h0);
		`CHK(r[2:0], 3'h3)
		bus(1'b1, 8'h34, 32'h3);
		bus(1'b0, 8'h34, 32'h0);
		`CHK(r[2:0], 3'h0)
		bus(1'b0, 8'h2C, 32'h0);
		`CHK(r[2:0], 3'h3)
		cyc(2);
		`CHK(irq, 1'b0)
		$display("faults end");
	endtask : t_fault
	task t_cont;
		bus(1'b1, 8'h20, 32'h1);
		on <= 1'b1;
		cyc(8);
		`CHK(co, 1'b1)
		`CHK(me, 1'b1)
		rs <= 1'b1;
		for (n = 0; co === 1'b1 && n < 700; n++) @(posedge clock);
		`CHK(n inside {[495:515]}, 1'b1)
		rs <= 1'b0;
		on <= 1'b0;
		for (int s = 0; s < 2; s++) begin
			bus(1'b1, 8'h20, 32'h1 + 32'h4 * s);
			on <= 1'b1;
			cyc(8);
			safe_torque_off <= 1'b1;
			cyc(20);
			`CHK(co, s[0])
			`CHK(me, 1'b0)
			on <= 1'b0;
			cyc(600);
			`CHK(co, 1'b0)
			safe_torque_off <= 1'b0;
		end
		$display("contactor end");
	endtask : t_cont
	task t_watch;
		bus(1'b1, 8'h20, 32'h3);
		on <= 1'b1;
		cyc(20);
		stuck <= 1'b1;
		on <= 1'b0;
		for (n = 0; co === 1'b1 && n < 700; n++) @(posedge clock);
		cyc(950);
		bus(1'b0, 8'h34, 32'h0);
		`CHK(r[2], 1'b0)
		cyc(100);
		bus(1'b0, 8'h34, 32'h0);
		`CHK(r[2], 1'b1)
		$display("feedback watch end");
	endtask : t_watch
	task close_out;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : close_out
	initial begin
		cyc(8);
		rst <= 1'b0;
		t_regs();
		t_buf();
		t_fault();
		t_cont();
		t_watch();
		close_out();
	end
	initial begin
		#400000;
		fails++;
		close_out();
	end
endmodule : lss_supervisor_bench
